//--- rtl/dmac_pkg.sv
// Constants, field layout and mode types of the multiply-accumulate block.
package dmac_pkg;

    // Datapath widths.
    localparam int DMAC_SLOTS = 8;    // Nine-bit input register slots per operand.
    localparam int DMAC_OPW   = 9;    // Bits per input register slot.
    localparam int DMAC_OPV   = 72;   // All slots of one operand side by side.
    localparam int DMAC_SHW   = 18;   // Width of one shift chain port.
    localparam int DMAC_XW    = 37;   // Operand widened by one sign-aware bit.
    localparam int DMAC_MULW  = 72;   // Widest full-precision product.
    localparam int DMAC_P9W   = 18;   // Product of two nine-bit operands.
    localparam int DMAC_P18W  = 36;   // Product of two eighteen-bit operands.
    localparam int DMAC_PRW   = 144;  // All products of the block packed.
    localparam int DMAC_ACCW  = 52;   // Accumulator: 36-bit product plus 16 bits headroom.
    localparam int DMAC_LANEW = 72;   // Output lane of a wide result.
    localparam int DMAC_OUTW  = 146;  // Packed results plus two overflow flags.
    localparam int DMAC_CTLW  = 6;    // Sign, add/subtract and load controls.
    localparam int DMAC_SETS  = 4;    // Shared clock, clear and enable sets.
    localparam int DMAC_SELW  = 2;    // Width of a control set select.

    // Register port.
    localparam int DMAC_AW = 8;
    localparam int DMAC_DW = 32;
    localparam logic [7:0] DMAC_OFS_MODE   = 8'h00;
    localparam logic [7:0] DMAC_OFS_SELIN  = 8'h04;
    localparam logic [7:0] DMAC_OFS_SELMSC = 8'h08;
    localparam logic [7:0] DMAC_OFS_STATUS = 8'h0C;

    // Mode register fields.
    localparam int DMAC_F_SIZE  = 0;
    localparam int DMAC_F_AMODE = 2;
    localparam int DMAC_F_SHA   = 4;
    localparam int DMAC_F_SHB   = 5;
    localparam int DMAC_F_INA   = 6;
    localparam int DMAC_F_INB   = 7;
    localparam int DMAC_F_CTL1  = 8;
    localparam int DMAC_F_CTL2  = 9;
    localparam int DMAC_F_PIPE  = 10;
    localparam int DMAC_F_OUT   = 11;

    // Select register fields; input selects are two bits per slot.
    localparam int DMAC_F_SELB  = 16;
    localparam int DMAC_F_SCTL1 = 0;
    localparam int DMAC_F_SCTL2 = 2;
    localparam int DMAC_F_SPIPE = 4;
    localparam int DMAC_F_SOUT  = 6;

    // Status register fields.
    localparam int DMAC_F_STOVF = 0;
    localparam int DMAC_F_STAM  = 2;

    // Reset values: nine-bit simple multiply, every register bypassed.
    localparam logic [31:0] DMAC_MODE_RST = 32'h0000_0000;
    localparam logic [31:0] DMAC_SEL_RST  = 32'h0000_0000;

    typedef enum logic [1:0] {DMAC_SZ_9, DMAC_SZ_18, DMAC_SZ_36} dmac_size_t;
    typedef enum logic [1:0] {DMAC_AM_SIMPLE, DMAC_AM_ACCUM,
                              DMAC_AM_ADD2, DMAC_AM_ADD4} dmac_amode_t;

endpackage

//--- rtl/dmac_reg.sv
// Bypassable register bank on one shared control set.
`timescale 1ns/10ps
module dmac_reg
    import dmac_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 use_reg,
    input  wire logic [DMAC_SELW-1:0] sel,
    input  wire logic [DMAC_SETS-1:0] set_tick,
    input  wire logic [DMAC_SETS-1:0] set_ena,
    input  wire logic [DMAC_SETS-1:0] set_aclr,
    input  wire logic [W-1:0]         d,
    output logic      [W-1:0]         q,
    output logic      [W-1:0]         y
);
    logic clr;

    // Reset joins the selected clear; clear lines must be glitch free.
    assign clr = ~rst_n | set_aclr[sel];

    // Clear wins at once; otherwise capture only on a tick with enable high.
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            q <= '0;
        end else if (set_tick[sel] & set_ena[sel]) begin
            q <= d;
        end
    end

    // A bypassed stage passes its input straight through.
    assign y = use_reg ? q : d;
endmodule // dmac_reg

//--- rtl/dmac_top.sv
// Multiply-accumulate block top.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - Each input register picks its own control set.
// - Shift mode also drives one shift output per operand.
// - Chain ends in any block; up to 224 registers.
// - Eight 9x9, four 18x18 or one 36x36 multiplier.
// - Sign control 1 means signed; product signed if either operand is.
// - Sign controls reach all multipliers and adders, optionally registered.
// - Products keep full precision for the chosen operand width.
// - Bypassable post-multiply register; at 36x36 it holds the whole product.
// - Adder stage: plain, accumulate, two-add or four-add.
// - Accumulate mode always uses the output registers.
// - Two add/subtract selects; at nine bits, upper and lower pairs.
// - Select high adds, select low subtracts.
// - Add/subtract select passes zero, one or two register stages.
// - Adder sign copies come from the same sources and set, up to twice.
// - Accumulate mode feeds the output back into the running total.
// - Load replaces the total with the product; zero to two stages.
// - Overflow or underflow flag is registered and not sticky.
// - Summation: two four-product sums at 9x9, one at 18x18.
// - Output mux picks product, adder result or summation result.
// - Output registers use one of the four shared control sets.
// - Accumulator is 52 bits: 36-bit product plus 16 bits headroom.
// - Only one adder mode at a time in the whole block.
module dmac_top
    import dmac_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [DMAC_AW-1:0]   reg_addr,
    input  wire logic [DMAC_DW-1:0]   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DMAC_DW-1:0]   reg_rdata,
    input  wire logic [DMAC_OPV-1:0]  data_a,
    input  wire logic [DMAC_OPV-1:0]  data_b,
    input  wire logic [DMAC_SHW-1:0]  shift_in_a,
    input  wire logic [DMAC_SHW-1:0]  shift_in_b,
    input  wire logic                 sign_a,
    input  wire logic                 sign_b,
    input  wire logic [1:0]           addnsub,
    input  wire logic [1:0]           accum_sload,
    input  wire logic [DMAC_SETS-1:0] set_tick,
    input  wire logic [DMAC_SETS-1:0] set_ena,
    input  wire logic [DMAC_SETS-1:0] set_aclr,
    output logic      [DMAC_PRW-1:0]  result,
    output logic      [1:0]           overflow,
    output logic      [DMAC_SHW-1:0]  shift_out_a_a,
    output logic      [DMAC_SHW-1:0]  shift_out_b_b
);

    // Signed multiply, cut to the widest product.
    function automatic [DMAC_MULW-1:0] smul(input [DMAC_XW-1:0] a,
                                            input [DMAC_XW-1:0] b);
        logic signed [2*DMAC_XW-1:0] p;
        p    = $signed(a) * $signed(b);
        smul = p[DMAC_MULW-1:0];
    endfunction

    // Widen a result to an output lane, copying the top bit.
    function automatic [DMAC_LANEW-1:0] lx(input [DMAC_ACCW-1:0] v);
        lx = {{(DMAC_LANEW-DMAC_ACCW){v[DMAC_ACCW-1]}}, v};
    endfunction

    logic [DMAC_DW-1:0] mode_ff;
    logic [DMAC_DW-1:0] selin_ff;
    logic [DMAC_DW-1:0] selmsc_ff;
    logic [DMAC_DW-1:0] rdata_ff;

    // Configuration registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff   <= DMAC_MODE_RST;
            selin_ff  <= DMAC_SEL_RST;
            selmsc_ff <= DMAC_SEL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                DMAC_OFS_MODE:   mode_ff   <= reg_wdata;
                DMAC_OFS_SELIN:  selin_ff  <= reg_wdata;
                DMAC_OFS_SELMSC: selmsc_ff <= reg_wdata;
                default:         mode_ff   <= mode_ff;
            endcase
        end
    end

    dmac_size_t  size;
    dmac_amode_t amode;
    logic        is9;
    logic        is36;
    logic        shf_a;
    logic        shf_b;
    logic        use_in_a;
    logic        use_in_b;
    logic        use_out;

    // Mode decode; size 36 forces plain output and parallel input.
    always_comb begin
        case (mode_ff[DMAC_F_SIZE +: 2])
            2'h0:    size = DMAC_SZ_9;
            2'h2:    size = DMAC_SZ_36;
            default: size = DMAC_SZ_18;
        endcase
        is9  = (size == DMAC_SZ_9);
        is36 = (size == DMAC_SZ_36);
        // One field holds the adder mode, so modes never mix in a block.
        amode = dmac_amode_t'(mode_ff[DMAC_F_AMODE +: 2]);
        if (is36) begin
            amode = DMAC_AM_SIMPLE;
        end
        shf_a    = mode_ff[DMAC_F_SHA] & ~is36;
        shf_b    = mode_ff[DMAC_F_SHB] & ~is36;
        use_in_a = mode_ff[DMAC_F_INA] | shf_a;
        use_in_b = mode_ff[DMAC_F_INB] | shf_b;
        use_out  = mode_ff[DMAC_F_OUT] | (amode == DMAC_AM_ACCUM);
    end

    logic [DMAC_OPV-1:0]  aq;
    logic [DMAC_OPV-1:0]  ay;
    logic [DMAC_OPV-1:0]  bq;
    logic [DMAC_OPV-1:0]  by;
    logic [DMAC_OPV-1:0]  sha;
    logic [DMAC_OPV-1:0]  shb;
    logic [DMAC_OPV-1:0]  din_a;
    logic [DMAC_OPV-1:0]  din_b;

    // Shift sources: each slot takes the one below at nine bits, the one two below at 18.
    assign sha = is9 ? {aq[DMAC_OPV-DMAC_OPW-1:0], shift_in_a[DMAC_OPW-1:0]}
                     : {aq[DMAC_OPV-DMAC_SHW-1:0], shift_in_a};
    assign shb = is9 ? {bq[DMAC_OPV-DMAC_OPW-1:0], shift_in_b[DMAC_OPW-1:0]}
                     : {bq[DMAC_OPV-DMAC_SHW-1:0], shift_in_b};
    assign din_a = shf_a ? sha : data_a;
    assign din_b = shf_b ? shb : data_b;

    // Shift outputs are the top slot, or the top two slots at 18 bits, so the chain can stop or go on.
    // The fabric sets the chain length by linking blocks.
    assign shift_out_a_a = is9 ? {{(DMAC_SHW-DMAC_OPW){1'b0}},
                                  aq[DMAC_OPV-1 -: DMAC_OPW]}
                               : aq[DMAC_OPV-1 -: DMAC_SHW];
    assign shift_out_b_b = is9 ? {{(DMAC_SHW-DMAC_OPW){1'b0}},
                                  bq[DMAC_OPV-1 -: DMAC_OPW]}
                               : bq[DMAC_OPV-1 -: DMAC_SHW];

    // One register per slot and operand.
    for (genvar k = 0; k < DMAC_SLOTS; k++) begin : g_in
        dmac_reg #(.W(DMAC_OPW)) u_ra (
            .clk      (clk),
            .rst_n    (rst_n),
            .use_reg  (use_in_a),
            .sel      (selin_ff[DMAC_SELW*k +: DMAC_SELW]),
            .set_tick (set_tick),
            .set_ena  (set_ena),
            .set_aclr (set_aclr),
            .d        (din_a[DMAC_OPW*k +: DMAC_OPW]),
            .q        (aq[DMAC_OPW*k +: DMAC_OPW]),
            .y        (ay[DMAC_OPW*k +: DMAC_OPW])
        );
        dmac_reg #(.W(DMAC_OPW)) u_rb (
            .clk      (clk),
            .rst_n    (rst_n),
            .use_reg  (use_in_b),
            .sel      (selin_ff[DMAC_F_SELB+DMAC_SELW*k +: DMAC_SELW]),
            .set_tick (set_tick),
            .set_ena  (set_ena),
            .set_aclr (set_aclr),
            .d        (din_b[DMAC_OPW*k +: DMAC_OPW]),
            .q        (bq[DMAC_OPW*k +: DMAC_OPW]),
            .y        (by[DMAC_OPW*k +: DMAC_OPW])
        );
    end

    logic [DMAC_CTLW-1:0] ctl0;
    logic [DMAC_CTLW-1:0] ctl1;
    logic [DMAC_CTLW-1:0] ctl2;

    // All controls share one chain, hence one source and set.
    assign ctl0 = {accum_sload, addnsub, sign_b, sign_a};

    dmac_reg #(.W(DMAC_CTLW)) u_ctl1 (
        .clk      (clk),
        .rst_n    (rst_n),
        .use_reg  (mode_ff[DMAC_F_CTL1]),
        .sel      (selmsc_ff[DMAC_F_SCTL1 +: DMAC_SELW]),
        .set_tick (set_tick),
        .set_ena  (set_ena),
        .set_aclr (set_aclr),
        .d        (ctl0),
        .q        (),
        .y        (ctl1)
    );

    // Second stage gives the adder copies up to two registers.
    dmac_reg #(.W(DMAC_CTLW)) u_ctl2 (
        .clk      (clk),
        .rst_n    (rst_n),
        .use_reg  (mode_ff[DMAC_F_CTL2]),
        .sel      (selmsc_ff[DMAC_F_SCTL2 +: DMAC_SELW]),
        .set_tick (set_tick),
        .set_ena  (set_ena),
        .set_aclr (set_aclr),
        .d        (ctl1),
        .q        (),
        .y        (ctl2)
    );

    logic                 sa1;
    logic                 sb1;
    logic [DMAC_PRW-1:0]  p9;
    logic [DMAC_PRW-1:0]  p18;
    logic [DMAC_MULW-1:0] p36;
    logic [DMAC_PRW-1:0]  prod_d;
    logic [DMAC_PRW-1:0]  prod_p;

    // Multipliers see the signs after the first control stage.
    assign sa1 = ctl1[0];
    assign sb1 = ctl1[1];

    // A sign-aware top bit lets one signed multiply serve all cases.
    for (genvar k = 0; k < DMAC_SLOTS; k++) begin : g_m9
        logic [DMAC_OPW-1:0]  a;
        logic [DMAC_OPW-1:0]  b;
        logic [DMAC_MULW-1:0] t;
        assign a = ay[DMAC_OPW*k +: DMAC_OPW];
        assign b = by[DMAC_OPW*k +: DMAC_OPW];
        assign t = smul({{(DMAC_XW-DMAC_OPW){sa1 & a[DMAC_OPW-1]}}, a},
                        {{(DMAC_XW-DMAC_OPW){sb1 & b[DMAC_OPW-1]}}, b});
        assign p9[DMAC_P9W*k +: DMAC_P9W] = t[DMAC_P9W-1:0];
    end

    for (genvar j = 0; j < DMAC_SLOTS/2; j++) begin : g_m18
        logic [DMAC_SHW-1:0]  a;
        logic [DMAC_SHW-1:0]  b;
        logic [DMAC_MULW-1:0] t;
        assign a = ay[DMAC_SHW*j +: DMAC_SHW];
        assign b = by[DMAC_SHW*j +: DMAC_SHW];
        assign t = smul({{(DMAC_XW-DMAC_SHW){sa1 & a[DMAC_SHW-1]}}, a},
                        {{(DMAC_XW-DMAC_SHW){sb1 & b[DMAC_SHW-1]}}, b});
        assign p18[DMAC_P18W*j +: DMAC_P18W] = t[DMAC_P18W-1:0];
    end

    // The 36-bit multiply uses the low four slots of each operand.
    assign p36 = smul({sa1 & ay[DMAC_P18W-1], ay[DMAC_P18W-1:0]},
                      {sb1 & by[DMAC_P18W-1], by[DMAC_P18W-1:0]});

    // Size select of the packed products.
    always_comb begin
        case (size)
            DMAC_SZ_9:  prod_d = p9;
            DMAC_SZ_36: prod_d = {{(DMAC_PRW-DMAC_MULW){1'b0}}, p36};
            default:    prod_d = p18;
        endcase
    end

    // Post-multiply register; at 36 bits it holds the whole 72-bit product.
    dmac_reg #(.W(DMAC_PRW)) u_pipe (
        .clk      (clk),
        .rst_n    (rst_n),
        .use_reg  (mode_ff[DMAC_F_PIPE]),
        .sel      (selmsc_ff[DMAC_F_SPIPE +: DMAC_SELW]),
        .set_tick (set_tick),
        .set_ena  (set_ena),
        .set_aclr (set_aclr),
        .d        (prod_d),
        .q        (),
        .y        (prod_p)
    );

    logic                 psg;
    logic [1:0]           ans;
    logic [1:0]           sld;
    logic [DMAC_ACCW-1:0] el [DMAC_SLOTS];
    logic [DMAC_ACCW-1:0] r  [DMAC_SLOTS/2];
    logic [DMAC_ACCW-1:0] s  [2];
    logic [DMAC_ACCW-1:0] acc[2];
    logic [1:0]           acc_ovf;
    logic [DMAC_OUTW-1:0] out_d;
    logic [DMAC_OUTW-1:0] oq;
    logic [DMAC_OUTW-1:0] oy;

    // Adder stage uses the second-stage controls.
    assign psg = ctl2[0] | ctl2[1];
    assign ans = ctl2[3:2];
    assign sld = ctl2[5:4];

    // Widen products to accumulator width, extending signed ones.
    for (genvar k = 0; k < DMAC_SLOTS; k++) begin : g_el
        if (k < DMAC_SLOTS/2) begin : g_wide
            logic [DMAC_P18W-1:0] w;
            assign w = prod_p[DMAC_P18W*k +: DMAC_P18W];
            assign el[k] = is9
                ? {{(DMAC_ACCW-DMAC_P9W){psg & prod_p[DMAC_P9W*k+DMAC_P9W-1]}},
                   prod_p[DMAC_P9W*k +: DMAC_P9W]}
                : {{(DMAC_ACCW-DMAC_P18W){psg & w[DMAC_P18W-1]}}, w};
        end else begin : g_narrow
            assign el[k] = is9
                ? {{(DMAC_ACCW-DMAC_P9W){psg & prod_p[DMAC_P9W*k+DMAC_P9W-1]}},
                   prod_p[DMAC_P9W*k +: DMAC_P9W]}
                : '0;
        end
    end

    // First-level adders; at nine bits two adders share a select.
    for (genvar m = 0; m < DMAC_SLOTS/2; m++) begin : g_add
        logic sel_add;
        assign sel_add = is9 ? ans[m/2] : ans[m%2];
        assign r[m] = sel_add ? el[2*m] + el[2*m+1]
                              : el[2*m] - el[2*m+1];
    end

    // Summation of two first-level results; the upper one is zero at 18 bits.
    assign s[0] = r[0] + r[1];
    assign s[1] = r[2] + r[3];

    // Accumulators run on the third multiplier of their half at nine bits, the second and fourth at 18.
    for (genvar i = 0; i < 2; i++) begin : g_acc
        logic [DMAC_ACCW-1:0] ae;
        logic [DMAC_ACCW-1:0] fb;
        logic                 xa;
        logic                 xf;
        logic [DMAC_ACCW:0]   c;
        assign ae = is9 ? el[4*i+2] : el[2*i+1];
        assign fb = oq[DMAC_LANEW*i +: DMAC_ACCW];
        assign xa = psg & ae[DMAC_ACCW-1];
        assign xf = psg & fb[DMAC_ACCW-1];
        always_comb begin
            if (sld[i]) begin
                c = {xa, ae};
            end else if (ans[i]) begin
                c = {xf, fb} + {xa, ae};
            end else begin
                c = {xf, fb} - {xa, ae};
            end
        end
        assign acc[i] = c[DMAC_ACCW-1:0];
        // Signed totals flag a top-bit disagreement; unsigned ones a carry.
        assign acc_ovf[i] = ~sld[i] & (psg ? c[DMAC_ACCW] ^ c[DMAC_ACCW-1]
                                           : c[DMAC_ACCW]);
    end

    // Output select; the two top bits carry the accumulator flags.
    always_comb begin
        case (amode)
            DMAC_AM_SIMPLE: out_d = {2'h0, prod_p};
            DMAC_AM_ACCUM:  out_d = {acc_ovf, lx(acc[1]), lx(acc[0])};
            DMAC_AM_ADD2: begin
                if (is9) begin
                    out_d = {2'h0, r[3][DMAC_P18W-1:0], r[2][DMAC_P18W-1:0],
                             r[1][DMAC_P18W-1:0], r[0][DMAC_P18W-1:0]};
                end else begin
                    out_d = {2'h0, lx(r[1]), lx(r[0])};
                end
            end
            DMAC_AM_ADD4:   out_d = {2'h0, lx(s[1]), lx(s[0])};
            default:        out_d = '0;
        endcase
    end

    // Output registers; flags are rebuilt each capture, never sticky.
    dmac_reg #(.W(DMAC_OUTW)) u_out (
        .clk      (clk),
        .rst_n    (rst_n),
        .use_reg  (use_out),
        .sel      (selmsc_ff[DMAC_F_SOUT +: DMAC_SELW]),
        .set_tick (set_tick),
        .set_ena  (set_ena),
        .set_aclr (set_aclr),
        .d        (out_d),
        .q        (oq),
        .y        (oy)
    );

    assign result   = oy[DMAC_PRW-1:0];
    assign overflow = oy[DMAC_OUTW-1 -: 2];

    // Read data stands one cycle after the strobe and is zero otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                DMAC_OFS_MODE:   rdata_ff <= mode_ff;
                DMAC_OFS_SELIN:  rdata_ff <= selin_ff;
                DMAC_OFS_SELMSC: rdata_ff <= selmsc_ff;
                DMAC_OFS_STATUS: begin
                    rdata_ff <= '0;
                    rdata_ff[DMAC_F_STOVF +: 2] <= oq[DMAC_OUTW-1 -: 2];
                    rdata_ff[DMAC_F_STAM +: 2]  <= amode;
                end
                default:         rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule // dmac_top

//--- tb/dmac_fabric.sv
// Fabric model: wide operand stage and flag latch.
`timescale 1ns/10ps
module dmac_fabric
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [35:0] op_in,
    input  wire logic [1:0]  ovf,
    output logic      [35:0] op_out,
    output logic      [1:0]  ovf_held
);
    // The fabric's own stage for wide operands.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_out <= 36'h0_0000_0000;
        end else begin
            op_out <= op_in;
        end
    end
    // The block's flag is not sticky, so it is latched here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_held <= 2'h0;
        end else begin
            ovf_held <= ovf_held | ovf;
        end
    end
endmodule // dmac_fabric

//--- tb/dmac_props.sv
// Port checker for the block.
`timescale 1ns/10ps
module dmac_props
    import dmac_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [DMAC_AW-1:0]   reg_addr,
    input  wire logic [DMAC_DW-1:0]   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [DMAC_DW-1:0]   reg_rdata,
    input  wire logic [DMAC_OPV-1:0]  data_a,
    input  wire logic [DMAC_OPV-1:0]  data_b,
    input  wire logic                 sign_a,
    input  wire logic                 sign_b,
    input  wire logic [1:0]           addnsub,
    input  wire logic [1:0]           accum_sload,
    input  wire logic [DMAC_SETS-1:0] set_tick,
    input  wire logic [DMAC_SETS-1:0] set_ena,
    input  wire logic [DMAC_SETS-1:0] set_aclr,
    input  wire logic [DMAC_PRW-1:0]  result,
    input  wire logic [1:0]           overflow
);
    logic        [11:0] mode_ff;
    logic        [7:0]  msc_ff;
    logic signed [17:0] p9;
    logic signed [51:0] p18;
    logic signed [71:0] p36;
    logic        [51:0] acc_sum;
    logic               acc;
    logic        [1:0]  eff;
    // Shadow of the mode and control select registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= 12'h000;
            msc_ff  <= 8'h00;
        end else if (reg_wr && reg_addr == DMAC_OFS_MODE) begin
            mode_ff <= reg_wdata[11:0];
        end else if (reg_wr && reg_addr == DMAC_OFS_SELMSC) begin
            msc_ff <= reg_wdata[7:0];
        end
    end
    // Reference products; an unsigned operand gets a zero top bit.
    assign p9 = $signed({sign_a & data_a[8], data_a[8:0]})
              * $signed({sign_b & data_b[8], data_b[8:0]});
    assign p18 = $signed({sign_a & data_a[35], data_a[35:18]})
               * $signed({sign_b & data_b[35], data_b[35:18]});
    assign p36 = $signed({sign_a & data_a[35], data_a[35:0]})
               * $signed({sign_b & data_b[35], data_b[35:0]});
    assign acc_sum = addnsub[0] ? result[51:0] + p18 : result[51:0] - p18;
    // Accumulator checks hold only with no write pending.
    assign acc = mode_ff == 12'h805 && msc_ff == 8'h00 && !reg_wr;
    assign eff = (mode_ff[1:0] == 2'h2) ? 2'h0 : mode_ff[3:2];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_mul9;
        mode_ff == 12'h000 && !reg_wr |-> result[17:0] == p9;
    endproperty
    a_mul9: assert property (p_mul9) else $error("nine-bit product");
    property p_mul36;
        mode_ff == 12'h002 && !reg_wr |-> result[71:0] == p36;
    endproperty
    a_mul36: assert property (p_mul36) else $error("wide product");
    property p_load;
        acc && accum_sload[0] && set_tick[0] && set_ena[0] && !set_aclr[0]
        |=> set_aclr[0] || result[51:0] == $past(p18);
    endproperty
    a_load: assert property (p_load) else $error("load missed");
    property p_step;
        acc && !accum_sload[0] && set_tick[0] && set_ena[0] && !set_aclr[0]
        |=> set_aclr[0] || result[51:0] == $past(acc_sum);
    endproperty
    a_step: assert property (p_step) else $error("total wrong");
    property p_hold;
        acc && !set_ena[0] && !set_aclr[0] |=> set_aclr[0] || $stable(result[51:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("total moved");
    property p_ovf;
        acc && accum_sload[0] && set_tick[0] && set_ena[0] |=> !overflow[0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("flag on load");
    property p_clr;
        acc && set_aclr[0] |-> result[51:0] == 52'h0_0000_0000_0000;
    endproperty
    a_clr: assert property (p_clr) else $error("clear missed");
    property p_status;
        reg_rd && reg_addr == DMAC_OFS_STATUS |=> reg_rdata[3:2] == $past(eff);
    endproperty
    a_status: assert property (p_status) else $error("mode wrong");
endmodule // dmac_props
bind dmac_top dmac_props i_props (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .data_a, .data_b, .sign_a, .sign_b, .addnsub, .accum_sload, .set_tick,
    .set_ena, .set_aclr, .result, .overflow);

//--- tb/dmac_top_tb.sv
// Bench for the multiply-accumulate block.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module dmac_top_tb
    import dmac_pkg::*;
;
    logic                 clk, rst_n, reg_wr, reg_rd, sign_a, sign_b;
    logic [DMAC_AW-1:0]   reg_addr;
    logic [DMAC_DW-1:0]   reg_wdata, reg_rdata;
    logic [DMAC_OPV-1:0]  data_b;
    logic [1:0]           addnsub, accum_sload, overflow, ovf_held;
    logic [DMAC_SETS-1:0] set_tick, set_ena, set_aclr;
    logic [DMAC_PRW-1:0]  result;
    logic [35:0]          op_in, op_out;
    int                   fails, compares;
    dmac_fabric i_fab (.clk, .rst_n, .op_in, .ovf(overflow), .op_out, .ovf_held);
    dmac_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .data_a({36'h0_0000_0000, op_out}), .data_b, .shift_in_a(18'h0_0000),
        .shift_in_b(18'h0_0000), .sign_a, .sign_b, .addnsub, .accum_sload, .set_tick,
        .set_ena, .set_aclr, .result, .overflow, .shift_out_a_a(), .shift_out_b_b());
    // Free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand for one cycle only.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata)
    endtask
    // One product; only the lane of its size is compared.
    task automatic mul(input logic w, input logic [35:0] a, input logic [35:0] b,
                       input logic [1:0] s);
        logic signed [71:0] e;
        logic        [71:0] m;
        e = $signed(w ? {s[1] & a[35], a} : {{28{s[1] & a[8]}}, a[8:0]})
          * $signed(w ? {s[0] & b[35], b} : {{28{s[0] & b[8]}}, b[8:0]});
        m = w ? {72{1'b1}} : 72'h00_0000_0000_0003_FFFF;
        @(posedge clk);
        op_in  <= a;
        data_b <= {36'h0_0000_0000, b};
        sign_a <= s[1];
        sign_b <= s[0];
        @(posedge clk);
        #1 `CHK("product", e & m, result[71:0] & m)
    endtask
    // Controls go in at an edge; the check sees the step before.
    task automatic stp(input logic sl, input logic ad, input logic en, input logic cl,
                       input logic [51:0] e);
        @(posedge clk);
        accum_sload <= {1'b0, sl};
        addnsub     <= {ad, ad};
        set_ena     <= {3'h7, en};
        set_aclr    <= {3'h0, cl};
        #1 `CHK("total", e, result[51:0])
    endtask
    task automatic stop_test;
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog: about fifty times the run.
    initial begin
        #(50 * 3000);
        fails++;
        stop_test;
    end
    // Reset values, the nine- and 36-bit products, then the accumulator.
    initial begin
        {fails, compares} = '0;
        {rst_n, reg_wr, reg_rd, sign_a, sign_b, reg_addr, reg_wdata} = '0;
        {addnsub, accum_sload, set_aclr, data_b, op_in} = '0;
        set_tick = 4'hF;
        set_ena  = 4'hF;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
        wr(DMAC_OFS_STATUS, 32'hF);
        rd(DMAC_OFS_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) mul(1'b0, 36'h1FF, 36'h1FE, 2'(i));
        wr(DMAC_OFS_MODE, 32'h2);
        for (int i = 0; i < 4; i++) mul(1'b1, 36'hF_FFFF_FFFF, 36'h8_0000_0003, 2'(i));
        wr(DMAC_OFS_MODE, 32'h6);
        rd(DMAC_OFS_STATUS, 32'h0);
        @(posedge clk);
        set_aclr <= 4'h1;
        op_in    <= 36'h5 << 18;
        data_b   <= 72'h7 << 18;
        {sign_a, sign_b} <= 2'b00;
        wr(DMAC_OFS_MODE, 32'h805);
        rd(DMAC_OFS_STATUS, 32'h4);
        stp(1'b1, 1'b1, 1'b1, 1'b0, 52'h0);
        stp(1'b0, 1'b1, 1'b1, 1'b0, 52'h23);
        stp(1'b0, 1'b0, 1'b1, 1'b0, 52'h46);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 52'h23);
        stp(1'b0, 1'b0, 1'b0, 1'b0, 52'h23);
        stp(1'b0, 1'b1, 1'b1, 1'b1, 52'h0);
        `CHK("ovf_held", 2'h0, ovf_held)
        stop_test;
    end
endmodule // dmac_top_tb
